/* verilog/mpa_top.sv */
// Monitor pin block: alert, reset pin, fuse and hot inputs, GPIO, strap, fans
`timescale 1ns/1ns
`include "mpa_defines.svh"
module mpa_top
	import mpa_pkg::*;
#(
	parameter int POR_CYCLES  = `MPA_POR_TIME_US * `MPA_CLK_MHZ,
	parameter int RAMP_CYCLES = `MPA_RAMP_TIME_US * `MPA_CLK_MHZ,
	parameter int GPIO_W      = 8
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	// Register port
	input  wire logic [5:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	// Alert pin, open drain
	output logic                   limit_event_out_n_o,
	output logic                   limit_event_out_n_oe_o,
	// Reset pin, two-way
	input  wire logic              reset_pin_n_i,
	output logic                   reset_pin_n_o,
	output logic                   reset_pin_n_oe_o,
	// Monitored inputs
	input  wire logic [1:0]        fuse_monitor_in_n_i,
	input  wire logic              regulator_hot_in_1_i,
	input  wire logic              regulator_hot_in_2_i,
	// Throttle pins, open drain
	output logic [1:0]             cpu_throttle_signal_n_o,
	output logic [1:0]             cpu_throttle_signal_n_oe_o,
	// General-purpose pins
	input  wire logic [GPIO_W-1:0] gpio_i,
	output logic      [GPIO_W-1:0] gpio_o,
	output logic      [GPIO_W-1:0] gpio_oe_o,
	// SMBus observation and address strap comparators
	input  wire logic              smb_clk_i,
	input  wire logic              smb_dat_i,
	input  wire logic              address_strap_hi_i,
	input  wire logic              address_strap_lo_i,
	// Fan outputs
	output logic                   fan_drive_out_1_o,
	output logic                   fan_drive_out_2_o
);
	// Elaboration check: pin map and counters assume these ranges
	if (GPIO_W != 8 || POR_CYCLES < 1 || RAMP_CYCLES < 1) begin : g_param_chk
		$error("mpa_top: unsupported parameter values");
	end

	localparam int SW = GPIO_W + 9;

	// Strap decode to slave address
	function automatic logic [6:0] strap_addr(input logic hi, input logic lo);
		if (hi) begin
			strap_addr = {`MPA_ADDR_PREFIX, 2'b01};
		end else if (lo) begin
			strap_addr = {`MPA_ADDR_PREFIX, 2'b00};
		end else begin
			strap_addr = {`MPA_ADDR_PREFIX, 2'b10};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [SW-1:0] raw_w;
	logic [SW-1:0] syn_w;
	logic          scl_s;
	logic          sda_s;
	logic          rst_pin_s;
	logic [1:0]    fuse_n_s;
	logic [1:0]    vrhot_s;
	logic          strap_hi_s;
	logic          strap_lo_s;
	logic [7:0]    gpio_s;
	logic [1:0]    warm_r;

	assign raw_w = {gpio_i, address_strap_lo_i, address_strap_hi_i,
		regulator_hot_in_2_i, regulator_hot_in_1_i, fuse_monitor_in_n_i,
		reset_pin_n_i, smb_dat_i, smb_clk_i};

	mpa_sync #(.W(SW)) u_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (raw_w),
		.q_o      (syn_w)
	);

	assign scl_s      = syn_w[0];
	assign sda_s      = syn_w[1];
	assign rst_pin_s  = syn_w[2];
	assign fuse_n_s   = syn_w[4:3];
	assign vrhot_s    = syn_w[6:5];
	assign strap_hi_s = syn_w[7];
	assign strap_lo_s = syn_w[8];
	assign gpio_s     = syn_w[SW-1:9];

	// Synchroniser reads zero for two edges after reset; active-low pins would fake events
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			warm_r <= 2'h0;
		end else begin
			warm_r <= {warm_r[0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-on reset pulse on the reset pin

	logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_r;
	logic                            por_done_r;
	logic                            rst_arm_r;
	logic                            ext_rst;

	// Pin driven low from reset release until the count runs out
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_cnt_r  <= '0;
			por_done_r <= 1'b0;
		end else if (!por_done_r) begin
			if (por_cnt_r == ($clog2(POR_CYCLES+1))'(POR_CYCLES - 1)) begin
				por_done_r <= 1'b1;
			end
			por_cnt_r <= por_cnt_r + 1'b1;
		end
	end

	// Pin outputs from flops; low level, enable in reset and while counting
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reset_pin_n_oe_o <= 1'b1;
			reset_pin_n_o    <= 1'b0;
		end else begin
			reset_pin_n_oe_o <= !por_done_r;
			reset_pin_n_o    <= 1'b0;
		end
	end

	// Armed once our own pulse has drained from the synchroniser
	// Limitation: a pin held low by others at power-up counts only after release
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_arm_r <= 1'b0;
		end else if (por_done_r && !reset_pin_n_oe_o && rst_pin_s) begin
			rst_arm_r <= 1'b1;
		end
	end

	// Without the arm our own low pulse would read as an external reset
	assign ext_rst = rst_arm_r && !rst_pin_s;

	////////////////////////////////////////////////////////////////////////
	// Register writes and control state

	logic        wr_ctrl;
	logic        wr_err;
	logic        wr_gerr;
	logic        alert_en_r;
	logic        lock_r;
	mpa_sleep_e  sleep_r;
	logic [7:0]  gpio_dir_r;
	logic [7:0]  gpio_out_r;
	logic [7:0]  gpi_mask_r;
	logic [7:0]  fan_cfg_r;
	logic [15:0] zone_temp_r;

	assign wr_ctrl = wr_i && addr_i == `MPA_REG_CTRL;
	assign wr_err  = wr_i && addr_i == `MPA_REG_ERR;
	assign wr_gerr = wr_i && addr_i == `MPA_REG_GPI_ERR;

	// Alert enable and lock; lock only sets from software
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			alert_en_r <= 1'b0;
			lock_r     <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				alert_en_r <= wdata_i[`MPA_CTRL_ALERT_EN];
			end
			if (ext_rst) begin
				lock_r <= 1'b0;
			end else if (wr_ctrl && wdata_i[`MPA_CTRL_LOCK]) begin
				lock_r <= 1'b1;
			end
		end
	end

	// Sleep state; external reset wins over a software write
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sleep_r <= MPA_SLP_S0;
		end else if (ext_rst) begin
			sleep_r <= MPA_SLP_SOFTOFF;
		end else if (wr_i && addr_i == `MPA_REG_SLEEP) begin
			case (wdata_i[1:0])
				2'b00:   sleep_r <= MPA_SLP_S0;
				2'b01:   sleep_r <= MPA_SLP_S3;
				2'b10:   sleep_r <= MPA_SLP_SOFTOFF;
				default: sleep_r <= sleep_r;
			endcase
		end
	end

	// Locked registers ignore writes, so a runaway host cannot misroute fans
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gpio_dir_r  <= 8'h00;
			gpio_out_r  <= 8'h00;
			gpi_mask_r  <= `MPA_GPI_MASK_RST;
			fan_cfg_r   <= `MPA_FAN_CFG_RST;
			zone_temp_r <= 16'h0000;
		end else if (wr_i) begin
			if (addr_i == `MPA_REG_GPIO_DIR && !lock_r) begin
				gpio_dir_r <= wdata_i[7:0];
			end
			if (addr_i == `MPA_REG_GPIO_OUT) begin
				gpio_out_r <= wdata_i[7:0];
			end
			if (addr_i == `MPA_REG_GPI_MASK) begin
				gpi_mask_r <= wdata_i[7:0];
			end
			if (addr_i == `MPA_REG_FAN_CFG && !lock_r) begin
				fan_cfg_r <= wdata_i[7:0];
			end
			if (addr_i == `MPA_REG_ZONE_TEMP) begin
				zone_temp_r <= wdata_i[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error events and status

	logic [7:0] err_r;
	logic [7:0] gerr_r;
	logic [7:0] err_set;
	logic [7:0] gerr_set;
	logic       evt_mask;
	logic       summary;

	// Soft-off and S3 hide fuse and GPI events while the host is down
	assign evt_mask = sleep_r != MPA_SLP_S0;
	assign err_set  = {2'b00, vrhot_s, vrhot_s,
		(evt_mask || !warm_r[1]) ? 2'b00 : ~fuse_n_s};
	assign gerr_set = evt_mask ? 8'h00 : (gpio_s & ~gpio_dir_r & ~gpi_mask_r);

	// Sticky bits, write one to clear, a same-cycle event wins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_r  <= 8'h00;
			gerr_r <= 8'h00;
		end else begin
			err_r  <= (err_r & ~(wr_err ? wdata_i[7:0] : 8'h00)) | err_set;
			gerr_r <= (gerr_r & ~(wr_gerr ? wdata_i[7:0] : 8'h00)) | gerr_set;
		end
	end

	// Throttle level bits stay out of the summary
	assign summary = |(err_r & `MPA_ERR_SUM_MASK) || |gerr_r;

	// Alert pin follows the summary one cycle on, dropping with disable
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			limit_event_out_n_oe_o <= 1'b0;
			limit_event_out_n_o    <= 1'b0;
		end else begin
			limit_event_out_n_oe_o <= alert_en_r && summary;
			limit_event_out_n_o    <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Throttle and GPIO pins

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cpu_throttle_signal_n_oe_o <= 2'b00;
			cpu_throttle_signal_n_o    <= 2'b00;
			gpio_oe_o                  <= 8'h00;
			gpio_o                     <= 8'h00;
		end else begin
			cpu_throttle_signal_n_oe_o <= vrhot_s;
			cpu_throttle_signal_n_o    <= 2'b00;
			gpio_oe_o                  <= gpio_dir_r;
			gpio_o                     <= gpio_out_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave address latch from the first matching address byte

	mpa_sniff_e sn_r;
	logic       scl_d_r;
	logic       sda_d_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r;
	logic       addr_ok_r;
	logic [6:0] addr_r;
	logic       start_c;
	logic       stop_c;
	logic       scl_rise;

	assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign scl_rise = scl_s && !scl_d_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// Address byte shifter, restarted by every start condition
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sn_r      <= MPA_SN_IDLE;
			bit_cnt_r <= 4'h0;
			sh_r      <= 8'h00;
		end else if (start_c) begin
			sn_r      <= MPA_SN_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (stop_c) begin
			sn_r <= MPA_SN_IDLE;
		end else begin
			case (sn_r)
				MPA_SN_IDLE: sn_r <= MPA_SN_IDLE;
				MPA_SN_ADDR: begin
					if (scl_rise) begin
						sh_r      <= {sh_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r == 4'h7) begin
							sn_r <= MPA_SN_WAIT;
						end
					end
				end
				MPA_SN_WAIT: sn_r <= MPA_SN_WAIT;
				default:     sn_r <= MPA_SN_IDLE;
			endcase
		end
	end

	// Latched once per power-up and never changed again
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			addr_ok_r <= 1'b0;
			addr_r    <= 7'h00;
		end else if (!addr_ok_r && sn_r == MPA_SN_WAIT && bit_cnt_r == 4'h8
				&& sh_r[7:3] == `MPA_ADDR_PREFIX) begin
			addr_ok_r <= 1'b1;
			addr_r    <= strap_addr(strap_hi_s, strap_lo_s);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fan channels

	logic [$clog2(RAMP_CYCLES+1)-1:0] ramp_cnt_r;
	logic                             ramp_tick_r;
	mpa_fan_if                        fan1 ();
	mpa_fan_if                        fan2 ();

	// Slow enable paces the duty ramp
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ramp_cnt_r  <= '0;
			ramp_tick_r <= 1'b0;
		end else begin
			ramp_tick_r <= ramp_cnt_r == ($clog2(RAMP_CYCLES+1))'(RAMP_CYCLES - 1);
			if (ramp_cnt_r == ($clog2(RAMP_CYCLES+1))'(RAMP_CYCLES - 1)) begin
				ramp_cnt_r <= '0;
			end else begin
				ramp_cnt_r <= ramp_cnt_r + 1'b1;
			end
		end
	end

	// Hottest assigned zone sets the target; a bound hot regulator forces full
	function automatic logic [7:0] fan_target(input logic [3:0] cfg,
			input logic [15:0] temps, input logic [1:0] hot);
		logic [7:0] t;
		t = 8'h00;
		if (cfg[0] && temps[7:0] > t) begin
			t = temps[7:0];
		end
		if (cfg[1] && temps[15:8] > t) begin
			t = temps[15:8];
		end
		if ((cfg[2] && hot[0]) || (cfg[3] && hot[1])) begin
			t = 8'hFF;
		end
		fan_target = t;
	endfunction

	assign fan1.target = fan_target(fan_cfg_r[3:0], zone_temp_r, vrhot_s);
	assign fan2.target = fan_target(fan_cfg_r[7:4], zone_temp_r, vrhot_s);
	assign fan1.tick   = ramp_tick_r;
	assign fan2.tick   = ramp_tick_r;

	mpa_fan u_fan1 (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.fi       (fan1.fan)
	);

	mpa_fan u_fan2 (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.fi       (fan2.fan)
	);

	assign fan_drive_out_1_o = fan1.pwm;
	assign fan_drive_out_2_o = fan2.pwm;

	////////////////////////////////////////////////////////////////////////
	// Register reads, one cycle after the strobe, zero otherwise

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				`MPA_REG_CTRL:      rdata_o <= {29'h0, lock_r, summary, alert_en_r};
				`MPA_REG_SLEEP:     rdata_o <= {30'h0, sleep_r};
				`MPA_REG_ERR:       rdata_o <= {24'h0, err_r};
				`MPA_REG_GPI_ERR:   rdata_o <= {24'h0, gerr_r};
				`MPA_REG_GPIO_DIR:  rdata_o <= {24'h0, gpio_dir_r};
				`MPA_REG_GPIO_OUT:  rdata_o <= {24'h0, gpio_out_r};
				`MPA_REG_GPIO_IN:   rdata_o <= {24'h0, gpio_s};
				`MPA_REG_GPI_MASK:  rdata_o <= {24'h0, gpi_mask_r};
				`MPA_REG_FAN_CFG:   rdata_o <= {24'h0, fan_cfg_r};
				`MPA_REG_ZONE_TEMP: rdata_o <= {16'h0, zone_temp_r};
				`MPA_REG_FAN_DUTY:  rdata_o <= {16'h0, fan2.duty, fan1.duty};
				`MPA_REG_ADDR:      rdata_o <= {24'h0, addr_ok_r, addr_r};
				default:            rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule

/* include/mpa_defines.svh */
// Offsets, field positions, reset values and timing counts of the monitor pin block
`ifndef MPA_DEFINES_SVH
`define MPA_DEFINES_SVH

// Register byte offsets
`define MPA_REG_CTRL      6'h00
`define MPA_REG_SLEEP     6'h04
`define MPA_REG_ERR       6'h08
`define MPA_REG_GPI_ERR   6'h0C
`define MPA_REG_GPIO_DIR  6'h10
`define MPA_REG_GPIO_OUT  6'h14
`define MPA_REG_GPIO_IN   6'h18
`define MPA_REG_GPI_MASK  6'h1C
`define MPA_REG_FAN_CFG   6'h20
`define MPA_REG_ZONE_TEMP 6'h24
`define MPA_REG_FAN_DUTY  6'h28
`define MPA_REG_ADDR      6'h2C

// Control register fields
`define MPA_CTRL_ALERT_EN 0
`define MPA_CTRL_SUMMARY  1
`define MPA_CTRL_LOCK     2

// Error status fields
`define MPA_ERR_FUSE_LSB  0
`define MPA_ERR_VRHOT_LSB 2
`define MPA_ERR_THR_LSB   4
`define MPA_ERR_SUM_MASK  8'h0F

// Reset values
`define MPA_CTRL_RST      3'h0
`define MPA_FAN_CFG_RST   8'h00
`define MPA_GPI_MASK_RST  8'hFF

// Addresses and timing
`define MPA_ADDR_PREFIX   5'h0B
`define MPA_POR_TIME_US   20
`define MPA_RAMP_TIME_US  40
`define MPA_CLK_MHZ       50

`endif

/* include/mpa_pkg.sv */
// Types shared by the monitor pin block
package mpa_pkg;

	typedef enum logic [1:0] {
		MPA_SLP_S0      = 2'b00,
		MPA_SLP_S3      = 2'b01,
		MPA_SLP_SOFTOFF = 2'b10
	} mpa_sleep_e;

	typedef enum logic [1:0] {
		MPA_SN_IDLE  = 2'b00,
		MPA_SN_ADDR  = 2'b01,
		MPA_SN_WAIT  = 2'b10
	} mpa_sniff_e;

	typedef logic [7:0] mpa_byte_t;

endpackage

/* include/mpa_fan_if.sv */
// Carrier between the pin block and one fan drive channel
`timescale 1ns/1ns
interface mpa_fan_if;
	logic [7:0] target;
	logic       tick;
	logic [7:0] duty;
	logic       pwm;
	modport ctrl (output target, output tick, input duty, input pwm);
	modport fan  (input target, input tick, output duty, output pwm);
endinterface

/* verilog/mpa_sync.sv */
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ns
module mpa_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

/* verilog/mpa_fan.sv */
// One fan drive channel: ramped duty and pulse-width output
`timescale 1ns/1ns
module mpa_fan (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// Control side
	mpa_fan_if.fan    fi
);
	logic [7:0] phase_r;
	logic [7:0] duty_r;
	logic       pwm_r;

	// Duty walks one step per tick, so a hot regulator brings the fan up gently
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			duty_r <= 8'h00;
		end else if (fi.tick) begin
			if (duty_r < fi.target) begin
				duty_r <= duty_r + 8'h01;
			end else if (duty_r > fi.target) begin
				duty_r <= duty_r - 8'h01;
			end
		end
	end

	// Free-running phase; full duty holds the output high
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_r <= 8'h00;
			pwm_r   <= 1'b0;
		end else begin
			phase_r <= phase_r + 8'h01;
			pwm_r   <= (duty_r == 8'hFF) || (phase_r < duty_r);
		end
	end

	assign fi.duty = duty_r;
	assign fi.pwm  = pwm_r;
endmodule

/* dv/mpa_smb_master.sv */
// Bus master model that sends one address byte per frame
`timescale 1ns/1ns
module mpa_smb_master (
	// Bus lines, pulled up
	output logic scl_o,
	output logic sda_o
);
	// Idle bus rests at the pull-up level; clock stands still outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// Start, eight bits most significant first, released ack slot, stop
	task automatic send(input logic [7:0] b);
		sda_o = 1'b0;
		#80;
		for (int i = 8; i >= 0; i--) begin
			scl_o = 1'b0;
			#40;
			sda_o = (i > 0) ? b[i-1] : 1'b1;
			#40;
			scl_o = 1'b1;
			#80;
		end
		scl_o = 1'b0;
		sda_o = 1'b0;
		#80;
		scl_o = 1'b1;
		#40;
		sda_o = 1'b1;
		#80;
	endtask
endmodule

/* dv/mpa_top_checker.sv */
// Port-level assertions for the monitor pin block
`timescale 1ns/1ns
`include "mpa_defines.svh"
module mpa_top_checker #(
	parameter int POR_CYCLES = 1000
) (
	// Clock, reset and register port
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic [5:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Pins
	input wire logic        limit_event_out_n_o,
	input wire logic        limit_event_out_n_oe_o,
	input wire logic        reset_pin_n_i,
	input wire logic        reset_pin_n_oe_o,
	input wire logic        regulator_hot_in_1_i,
	input wire logic        regulator_hot_in_2_i,
	input wire logic [1:0]  cpu_throttle_signal_n_oe_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	int   cnt_r;
	logic ext_low;
	////////////////////////////////////////////////////////////////
	// Cycles since release, saturating so it never wraps
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 0;
		end else if (cnt_r < POR_CYCLES + 3) begin
			cnt_r <= cnt_r + 1;
		end
	end
	// Pin held low from outside, no write muddying the lock
	assign ext_low = !reset_pin_n_i && !reset_pin_n_oe_o && !wr_i;
	////////////////////////////////////////////////////////////////
	property p_alert_drive;
		limit_event_out_n_oe_o |-> !limit_event_out_n_o;
	endproperty
	a_alert_drive: assert property (p_alert_drive)
		else $error("alert pin driven high");
	property p_alert_sum;
		rd_i && addr_i == `MPA_REG_CTRL |=> limit_event_out_n_oe_o == (rdata_o[0] & rdata_o[1]);
	endproperty
	a_alert_sum: assert property (p_alert_sum)
		else $error("alert pin differs from summary");
	property p_alert_off;
		wr_i && addr_i == `MPA_REG_CTRL && !wdata_i[0] |=> ##1 !limit_event_out_n_oe_o;
	endproperty
	a_alert_off: assert property (p_alert_off)
		else $error("alert held after disable");
	property p_por_hold;
		cnt_r < POR_CYCLES |-> reset_pin_n_oe_o;
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("reset pin released early");
	property p_por_release;
		cnt_r > POR_CYCLES + 2 |-> !reset_pin_n_oe_o;
	endproperty
	a_por_release: assert property (p_por_release)
		else $error("reset pin still driven");
	property p_thr1;
		$stable(regulator_hot_in_1_i) [*4] |-> cpu_throttle_signal_n_oe_o[0] == regulator_hot_in_1_i;
	endproperty
	a_thr1: assert property (p_thr1)
		else $error("throttle 1 not following hot input");
	property p_thr2;
		$stable(regulator_hot_in_2_i) [*4] |-> cpu_throttle_signal_n_oe_o[1] == regulator_hot_in_2_i;
	endproperty
	a_thr2: assert property (p_thr2)
		else $error("throttle 2 not following hot input");
	property p_unlock;
		ext_low [*4] ##0 (rd_i && addr_i == `MPA_REG_CTRL) |=> !rdata_o[`MPA_CTRL_LOCK];
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("lock kept under external reset");
	property p_softoff;
		ext_low [*4] ##0 (rd_i && addr_i == `MPA_REG_SLEEP) |=> rdata_o[1:0] == 2'b10;
	endproperty
	a_softoff: assert property (p_softoff)
		else $error("sleep state not forced to soft-off");
endmodule
bind mpa_top mpa_top_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .limit_event_out_n_o(limit_event_out_n_o),
	.limit_event_out_n_oe_o(limit_event_out_n_oe_o), .reset_pin_n_i(reset_pin_n_i),
	.reset_pin_n_oe_o(reset_pin_n_oe_o), .regulator_hot_in_1_i(regulator_hot_in_1_i),
	.regulator_hot_in_2_i(regulator_hot_in_2_i),
	.cpu_throttle_signal_n_oe_o(cpu_throttle_signal_n_oe_o)
);

/* dv/mpa_top_tb.sv */
// Self-checking bench for the monitor pin block
`timescale 1ns/1ns
`include "mpa_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module mpa_top_tb;
	import mpa_pkg::*;
	localparam int POR = 8;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [5:0]  addr_i = '0;
	logic [31:0] wdata_i = '0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o, d, e;
	logic        alert_n, alert_oe, rst_n, rst_o, rst_oe, ext_n = 1'b1, scl, sda, fan1, fan2;
	logic        hot1 = 1'b0, hot2 = 1'b0, st_hi = 1'b0, st_lo = 1'b0;
	logic [1:0]  fuse_n = 2'b11, thr_oe, thr_o;
	logic [7:0]  gpio_i, gpio_o, gpio_oe, ext = '0, t1, t2, dir, outv;
	int          seed = 32'h838d_6fe3;
	int          err_count = 0;
	int          n_checks = 0;
	// Wire levels: device pulls low or drives, else the outside sets them
	assign rst_n  = rst_oe ? rst_o : ext_n;
	assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);
	always #10 clk_i = ~clk_i;
	mpa_smb_master smb (.scl_o(scl), .sda_o(sda));
	mpa_top #(.POR_CYCLES(POR), .RAMP_CYCLES(2), .GPIO_W(8)) DUT (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .limit_event_out_n_o(alert_n),
		.limit_event_out_n_oe_o(alert_oe), .reset_pin_n_i(rst_n), .reset_pin_n_o(rst_o),
		.reset_pin_n_oe_o(rst_oe), .fuse_monitor_in_n_i(fuse_n),
		.regulator_hot_in_1_i(hot1), .regulator_hot_in_2_i(hot2),
		.cpu_throttle_signal_n_o(thr_o), .cpu_throttle_signal_n_oe_o(thr_oe),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .smb_clk_i(scl),
		.smb_dat_i(sda), .address_strap_hi_i(st_hi), .address_strap_lo_i(st_lo),
		.fan_drive_out_1_o(fan1), .fan_drive_out_2_o(fan2));
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Bus cycles leave one idle cycle so no strobe is set twice in a step
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [5:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge clk_i);
	endtask
	task automatic send(input logic [7:0] b);
		// Off the clock edge so bus lines never race the synchroniser
		#5;
		smb.send(b);
		cyc(4);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [6:0] exp_addr(input logic hi, input logic lo);
		return hi ? 7'h2D : (lo ? 7'h2C : 7'h2E);
	endfunction
	// Highest enabled zone, or zero when no zone is enabled; hot inputs are not modelled
	function automatic logic [7:0] exp_duty(input logic [3:0] c, input logic [7:0] z1, z2);
		logic [7:0] m;
		m = 8'h00;
		if (c[0] && z1 > m) m = z1;
		if (c[1] && z2 > m) m = z2;
		return m;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		stop_test();
	end
	initial begin
		// One power-up per strap level: the address latches only once
		for (int k = 0; k < 3; k++) begin
			st_hi <= (k == 0);
			st_lo <= (k == 2);
			arst_n_i <= 1'b0;
			cyc(20);
			arst_n_i <= 1'b1;
			cyc(1);
			`CHK(rst_oe, 1'b1)
			`CHK(rst_n, 1'b0)
			rd(`MPA_REG_CTRL);
			`CHK(d, 32'h0000_0000)
			rd(`MPA_REG_GPI_MASK);
			`CHK(d[7:0], 8'hFF)
			cyc(POR + 4);
			`CHK(rst_oe, 1'b0)
			rd(`MPA_REG_SLEEP);
			`CHK(d[1:0], 2'b00)
			send(8'hA0);
			rd(`MPA_REG_ADDR);
			`CHK(d[7], 1'b0)
			send(8'h5E);
			e = {24'h0000_00, 1'b1, exp_addr(st_hi, st_lo)};
			rd(`MPA_REG_ADDR);
			`CHK(d, e)
			st_hi <= ~st_hi;
			st_lo <= 1'b0;
			send(8'h5A);
			rd(`MPA_REG_ADDR);
			`CHK(d, e)
		end
		// Fuse event seen by polling, then alert enable, disable, re-enable
		wr(`MPA_REG_SLEEP, 32'h0000_0000);
		fuse_n <= 2'b10;
		cyc(4);
		rd(`MPA_REG_ERR);
		`CHK(d[1:0], 2'b01)
		rd(`MPA_REG_CTRL);
		`CHK(d[2:0], 3'b010)
		// Pin settles after the edge that ends the write, so look 1 ns on
		wr(`MPA_REG_CTRL, 32'h0000_0001);
		#1;
		`CHK(alert_oe, 1'b1)
		`CHK(alert_n, 1'b0)
		wr(`MPA_REG_CTRL, 32'h0000_0000);
		#1;
		`CHK(alert_oe, 1'b0)
		wr(`MPA_REG_CTRL, 32'h0000_0001);
		#1;
		`CHK(alert_oe, 1'b1)
		fuse_n <= 2'b11;
		cyc(4);
		wr(`MPA_REG_ERR, 32'h0000_0001);
		cyc(1);
		`CHK(alert_oe, 1'b0)
		// Hot input: throttle, error bits, gradual ramp of the bound fan
		wr(`MPA_REG_FAN_CFG, 32'h0000_0004);
		hot1 <= 1'b1;
		cyc(5);
		`CHK(thr_oe, 2'b01)
		`CHK(thr_o & thr_oe, 2'b00)
		rd(`MPA_REG_ERR);
		`CHK(d[5:0], 6'h14)
		rd(`MPA_REG_FAN_DUTY);
		`CHK(d[7:0] != 8'hFF, 1'b1)
		cyc(600);
		rd(`MPA_REG_FAN_DUTY);
		`CHK(d[7:0], 8'hFF)
		`CHK(fan1, 1'b1)
		`CHK(fan2, 1'b0)
		hot1 <= 1'b0;
		cyc(5);
		wr(`MPA_REG_ERR, 32'h0000_000C);
		cyc(1);
		`CHK(alert_oe, 1'b0)
		// Random zone temperatures drive both fans
		t1 = 8'($random(seed));
		t2 = 8'($random(seed));
		wr(`MPA_REG_ZONE_TEMP, {16'h0000, t2, t1});
		wr(`MPA_REG_FAN_CFG, 32'h0000_0021);
		cyc(700);
		rd(`MPA_REG_FAN_DUTY);
		`CHK(d[15:0], {exp_duty(4'h2, t1, t2), exp_duty(4'h1, t1, t2)})
		// Random direction and levels, then one unmasked input pin
		dir = 8'($random(seed));
		outv = 8'($random(seed));
		ext <= 8'($random(seed));
		wr(`MPA_REG_GPIO_DIR, {24'h0000_00, dir});
		wr(`MPA_REG_GPIO_OUT, {24'h0000_00, outv});
		cyc(4);
		`CHK(gpio_oe, dir)
		`CHK(gpio_o & dir, outv & dir)
		rd(`MPA_REG_GPIO_IN);
		`CHK(d[7:0], (dir & outv) | (~dir & ext))
		wr(`MPA_REG_GPIO_DIR, 32'h0000_0000);
		wr(`MPA_REG_GPI_ERR, 32'h0000_00FF);
		wr(`MPA_REG_GPI_MASK, 32'h0000_00FE);
		ext <= 8'h03;
		cyc(4);
		rd(`MPA_REG_GPI_ERR);
		`CHK(d[7:0], 8'h01)
		rd(6'h3C);
		`CHK(d, 32'h0000_0000)
		// External reset: unlock, soft-off, fuse events masked
		wr(`MPA_REG_CTRL, 32'h0000_0004);
		rd(`MPA_REG_CTRL);
		`CHK(d[2], 1'b1)
		ext_n <= 1'b0;
		cyc(4);
		rd(`MPA_REG_CTRL);
		`CHK(d[2], 1'b0)
		rd(`MPA_REG_SLEEP);
		`CHK(d[1:0], 2'b10)
		ext_n <= 1'b1;
		wr(`MPA_REG_ERR, 32'h0000_0003);
		fuse_n <= 2'b01;
		cyc(4);
		rd(`MPA_REG_ERR);
		`CHK(d[1:0], 2'b00)
		`CHK(rst_oe, 1'b0)
		stop_test();
	end
endmodule
